// *** core/power_seq_pkg.sv ***
// What the host and this block must do
// RQ1: Host keeps clock enables low, chip selects high, 8 cycles before reset release.
// RQ2: Host leaves at least 8 cycles between two command word programming accesses.
// RQ3: With both enables low and power save on, inputs off after 1 to 4 cycles.
// RQ4: Outputs float 1.5 cycles after clock enable outputs are driven low.
// RQ5: Host holds both enables low 5 cycles before stopping the clock.
// RQ6: Enable input buffers turn off at least 2 cycles after the clock stops.
// RQ7: Static outputs return 1 to 3 cycles after either enable goes high.
// RQ8: In the test band only band two timing applies; application band meets all.
// RQ9: Power saving entered only with both enables low and power save bit set.
package power_seq_pkg;

    // ========================================
    // Timing figures in clock periods; output float in tenths of a period.
    localparam int RESET_LEAD_TCK = 8;
    localparam int COMMAND_SPACING_TCK = 8;
    localparam int INPUT_DISABLE_TCK = 2;
    localparam int OUTPUT_FLOAT_TENTHS_TCK = 15;
    localparam int CLOCK_STOP_LEAD_TCK = 5;
    localparam int ENABLE_DISABLE_TCK = 2;
    localparam int STATIC_RETURN_TCK = 2;

    // ========================================
    // Derived cycle counts at one cycle per clock period.
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] SPACING_CYCLES = CNT_W'(COMMAND_SPACING_TCK);
    localparam logic [CNT_W-1:0] INDIS_CYCLES = CNT_W'(INPUT_DISABLE_TCK);
    localparam logic [CNT_W-1:0] FLOAT_CYCLES = CNT_W'((OUTPUT_FLOAT_TENTHS_TCK + 9) / 10);
    localparam logic [CNT_W-1:0] CKEV_CYCLES = CNT_W'(ENABLE_DISABLE_TCK);
    localparam logic [CNT_W-1:0] RETURN_CYCLES = CNT_W'(STATIC_RETURN_TCK);
    localparam logic [CNT_W-1:0] COUNT_RESET = 4'h0;

    // ========================================
    // Carriers.
    typedef struct packed {
        logic enable;
        logic option;
    } power_word_t;

    typedef struct packed {
        logic input_buffers_on;
        logic enable_buffers_on;
        logic outputs_driven;
        logic static_outputs_valid;
    } buffer_ctrl_t;

    localparam buffer_ctrl_t BUFFERS_RESET = 4'hf;

    typedef enum logic [2:0] {
        ACTIVE,
        ENTERING,
        PARKED,
        FLOATED,
        STOPPED,
        EXITING
    } seq_state_t;

endpackage

// *** core/cycle_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module cycle_counter
    import power_seq_pkg::*;
(
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Control.
    input wire logic clear_in,
    // Count.
    output logic [CNT_W-1:0] count_out
);
    logic [CNT_W-1:0] next_count;

    // ========================================
    // Saturating count, cleared to zero.
    always_comb
    begin
        if (clear_in)
            next_count = COUNT_RESET;
        else if (&count_out)
            next_count = count_out;
        else
            next_count = count_out + 4'h1;
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            count_out <= COUNT_RESET;
        else
            count_out <= next_count;
    end
endmodule // cycle_counter
`default_nettype wire

// *** core/power_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module power_sequencer
(
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Host side inputs.
    input wire logic [1:0] clock_enable_inputs_in,
    input wire logic [3:0] chip_select_inputs_in,
    input wire power_seq_pkg::power_word_t power_save_control_word_in,
    input wire logic command_write_in,
    input wire logic clock_stopped_in,
    input wire logic test_band_in,
    // Device side outputs.
    output logic [1:0] clock_enable_outputs_out,
    output power_seq_pkg::buffer_ctrl_t buffers_out,
    output logic spacing_violation_out
);
    import power_seq_pkg::*;

    seq_state_t state;
    seq_state_t next_state;
    logic [CNT_W-1:0] state_count;
    logic [CNT_W-1:0] spacing_count;
    logic seen_write;
    logic next_seen_write;
    logic next_violation;
    logic [1:0] next_cke_out;
    buffer_ctrl_t next_buffers;
    logic both_low;
    logic any_high;
    logic power_save_on;
    logic timer_clear;

    // ========================================
    // Helpers.
    function automatic logic count_done(input logic [CNT_W-1:0] count, input logic [CNT_W-1:0] cycles);
        return count == cycles - 4'h1;
    endfunction

    function automatic logic is_saving(input seq_state_t s);
        return s inside {PARKED, FLOATED, STOPPED};
    endfunction

    assign both_low = ~|clock_enable_inputs_in;
    assign any_high = |clock_enable_inputs_in;
    assign power_save_on = power_save_control_word_in.enable;

    // ========================================
    // Counters.
    // Counting in FLOATED restarts whenever the clock is seen running again.
    assign timer_clear = (next_state != state) || (state == FLOATED && !clock_stopped_in); // see RQ6

    cycle_counter state_timer (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .clear_in(timer_clear),
        .count_out(state_count)
    );

    cycle_counter spacing_timer (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .clear_in(command_write_in),
        .count_out(spacing_count)
    );

    // ========================================
    // Power save sequence.
    always_comb
    begin
        next_state = state;
        case (state)
            ACTIVE:
                if (both_low && power_save_on) // see RQ9
                    next_state = ENTERING;
            ENTERING:
                if (any_high || !power_save_on) // see RQ9
                    next_state = EXITING;
                else if (count_done(state_count, INDIS_CYCLES)) // see RQ3
                    next_state = PARKED;
            PARKED:
                if (any_high) // see RQ7
                    next_state = EXITING;
                else if (count_done(state_count, FLOAT_CYCLES)) // see RQ4
                    next_state = FLOATED;
            FLOATED:
                if (any_high)
                    next_state = EXITING;
                else if (!clock_stopped_in) // see RQ5
                    next_state = FLOATED;
                else if (state_count == CKEV_CYCLES) // see RQ6
                    next_state = STOPPED;
            STOPPED:
                if (any_high)
                    next_state = EXITING;
            EXITING:
                // Both frequency bands use the same return count, inside band two limits.
                if (count_done(state_count, RETURN_CYCLES)) // see RQ7, see RQ8
                    next_state = ACTIVE;
            default:
                next_state = ACTIVE;
        endcase
    end

    // Buffer controls follow the state being entered.
    always_comb
    begin
        next_buffers.input_buffers_on = !is_saving(next_state); // see RQ3
        next_buffers.outputs_driven = !(next_state inside {FLOATED, STOPPED}); // see RQ4
        next_buffers.enable_buffers_on = next_state != STOPPED; // see RQ6
        next_buffers.static_outputs_valid = next_state inside {ACTIVE, ENTERING}; // see RQ7
        next_cke_out = next_buffers.input_buffers_on ? clock_enable_inputs_in : 2'h0;
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= ACTIVE;
            buffers_out <= BUFFERS_RESET;
            clock_enable_outputs_out <= 2'h0;
        end
        else
        begin
            state <= next_state;
            buffers_out <= next_buffers;
            clock_enable_outputs_out <= next_cke_out;
        end
    end

    // ========================================
    // Command word spacing monitor; the first cycles after reset rely on a quiet host.
    always_comb
    begin
        next_seen_write = seen_write | command_write_in;
        next_violation = command_write_in && seen_write && (spacing_count < SPACING_CYCLES - 4'h1); // see RQ2, see RQ1
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            seen_write <= 1'b0;
            spacing_violation_out <= 1'b0;
        end
        else
        begin
            seen_write <= next_seen_write;
            spacing_violation_out <= next_violation;
        end
    end

    // ========================================
    // Checks.
    logic entry_seen;
    assign entry_seen = (state == ACTIVE) && both_low && power_save_on;

    chk_indis_early: assert property (@(posedge clock_in) disable iff (rst_in) // see RQ3
        entry_seen |=> buffers_out.input_buffers_on)
        else $error("input buffers disabled too early");

    chk_indis_late: assert property (@(posedge clock_in) disable iff (rst_in) // see RQ3
        entry_seen ##1 (both_low && power_save_on)[*2] |=> !buffers_out.input_buffers_on)
        else $error("input buffers not disabled in time");

    chk_float_time: assert property (@(posedge clock_in) disable iff (rst_in) // see RQ4
        $fell(buffers_out.input_buffers_on) ##0 both_low ##1 both_low
        |-> (clock_enable_outputs_out == 2'h0) && buffers_out.outputs_driven ##1 !buffers_out.outputs_driven)
        else $error("outputs did not float after the set delay");

    chk_enable_buffers: assert property (@(posedge clock_in) disable iff (rst_in) // see RQ6
        (state == FLOATED && both_low && $rose(clock_stopped_in))
        |=> (buffers_out.enable_buffers_on)[*2])
        else $error("enable buffers disabled too early");

    chk_enable_off: assert property (@(posedge clock_in) disable iff (rst_in) // see RQ6
        (state == FLOATED && both_low && clock_stopped_in)[*3] |=> !buffers_out.enable_buffers_on)
        else $error("enable buffers not disabled after clock stop");

    chk_cke_forced: assert property (@(posedge clock_in) disable iff (rst_in) // see RQ3
        !buffers_out.input_buffers_on |-> clock_enable_outputs_out == 2'h0)
        else $error("clock enable outputs not held low");

    chk_exit_restores: assert property (@(posedge clock_in) disable iff (rst_in) // see RQ9
        (is_saving(state) && any_high)
        |=> buffers_out.input_buffers_on && buffers_out.outputs_driven && buffers_out.enable_buffers_on)
        else $error("buffers not restored on exit");

    chk_abort_entry: assert property (@(posedge clock_in) disable iff (rst_in) // see RQ9
        (state == ENTERING && (any_high || !power_save_on)) |=> state == EXITING)
        else $error("entry not abandoned on exit condition");

    chk_static_return: assert property (@(posedge clock_in) disable iff (rst_in) // see RQ7
        (is_saving(state) && any_high)
        |-> ##[1:3] buffers_out.static_outputs_valid)
        else $error("static outputs late after exit");

    chk_test_band: assert property (@(posedge clock_in) disable iff (rst_in) // see RQ8
        (test_band_in && state == EXITING && $past(state) != EXITING)
        |-> ##[0:2] buffers_out.static_outputs_valid)
        else $error("test band return too slow");

    chk_no_entry: assert property (@(posedge clock_in) disable iff (rst_in) // see RQ9
        (state == ACTIVE && !(both_low && power_save_on)) |=> state == ACTIVE)
        else $error("power save entered without its conditions");

    chk_spacing_flag: assert property (@(posedge clock_in) disable iff (rst_in) // see RQ2
        command_write_in ##1 (!command_write_in)[*6] ##1 command_write_in |=> spacing_violation_out)
        else $error("close command writes not flagged");

    chk_spacing_legal: assert property (@(posedge clock_in) disable iff (rst_in) // see RQ2
        command_write_in ##1 (!command_write_in)[*7] ##1 command_write_in |=> !spacing_violation_out)
        else $error("legally spaced command writes flagged");

    cov_float: cover property (@(posedge clock_in) disable iff (rst_in)
        $fell(buffers_out.outputs_driven));
    cov_stop: cover property (@(posedge clock_in) disable iff (rst_in)
        $fell(buffers_out.enable_buffers_on));
    cov_exit: cover property (@(posedge clock_in) disable iff (rst_in)
        state == STOPPED ##1 state == EXITING);
    cov_abort: cover property (@(posedge clock_in) disable iff (rst_in)
        state == ENTERING ##1 state == EXITING);
    cov_spacing: cover property (@(posedge clock_in) disable iff (rst_in)
        $rose(spacing_violation_out));
endmodule // power_sequencer
`default_nettype wire

// *** dv/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    // Clock.
    input wire logic clock_in,
    // Host side drives.
    output logic [1:0] clock_enable_out,
    output logic [3:0] chip_select_n_out,
    output power_seq_pkg::power_word_t word_out,
    output logic write_out,
    output logic stop_out
);
    import power_seq_pkg::*;

    // ========================================
    // Idle levels held through reset.
    initial
    begin
        clock_enable_out = 2'h0;
        chip_select_n_out = 4'hf;
        word_out = 2'h0;
        write_out = 1'b0;
        stop_out = 1'b0;
    end

    // ========================================
    // Host requests.
    task automatic drive(input logic [1:0] cke, input logic stop, input power_word_t word);
        @(posedge clock_in);
        #1 clock_enable_out = cke;
        stop_out = stop;
        word_out = word;
    endtask

    task automatic stop_clock();
        repeat (CLOCK_STOP_LEAD_TCK) @(posedge clock_in);
        #1 stop_out = 1'b1;
    endtask

    task automatic write_cmd(input int spacing);
        repeat (spacing - 2) @(posedge clock_in);
        @(posedge clock_in);
        #1 write_out = 1'b1;
        @(posedge clock_in);
        #1 write_out = 1'b0;
    endtask
endmodule // host_model
`default_nettype wire

// *** dv/power_sequencer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module power_sequencer_bench;
    import power_seq_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic test_band = 1'b0;
    logic [1:0] cke, cke_q, v;
    logic [3:0] cs_n;
    power_word_t word;
    logic wr, stop, viol;
    buffer_ctrl_t buf_q;
    logic exp_viol = 1'b0;
    int bad_count = 0;
    int total_checks = 0;
    int seed = 32'hfd09;
    int cyc = 0;
    int last_wr = -1;
    int n;

    host_model i_host (.clock_in(clock_in), .clock_enable_out(cke), .chip_select_n_out(cs_n),
        .word_out(word), .write_out(wr), .stop_out(stop));
    power_sequencer i_dut (.clock_in(clock_in), .rst_in(rst_in), .clock_enable_inputs_in(cke),
        .chip_select_inputs_in(cs_n), .power_save_control_word_in(word), .command_write_in(wr),
        .clock_stopped_in(stop), .test_band_in(test_band), .clock_enable_outputs_out(cke_q),
        .buffers_out(buf_q), .spacing_violation_out(viol));

    initial
    begin
        forever #2 clock_in = ~clock_in;
    end

    // ========================================
    // Compare and closing tasks.
    task automatic check_val(input string what, input logic [3:0] exp, input logic [3:0] got);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_range(input string what, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi)
        begin
            bad_count++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wait_bit(input int idx, input logic val);
        n = 0;
        while (buf_q[idx] !== val && n < 20)
        begin
            @(negedge clock_in);
            n++;
        end
    endtask

    // ========================================
    // Spacing model and timeout.
    always @(posedge clock_in)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            bad_count++;
            finish_test();
        end
        else if (rst_in)
            last_wr = -1;
        else
        begin
            exp_viol = wr && last_wr >= 0 && cyc - last_wr < COMMAND_SPACING_TCK;
            if (wr)
                last_wr = cyc;
        end
    end

    always @(negedge clock_in)
    begin
        if (!rst_in)
            check_val("spacing_violation", {3'h0, exp_viol}, {3'h0, viol});
    end

    // ========================================
    // Main sequence.
    initial
    begin
        repeat (10) @(posedge clock_in);
        check_val("reset_buffers", 4'hf, buf_q);
        check_val("reset_cke", 4'h0, {2'h0, cke_q});
        #1 rst_in = 1'b0;
        i_host.write_cmd(2);
        i_host.write_cmd(8);
        i_host.write_cmd(7);
        repeat (12) i_host.write_cmd(2 + ($random(seed) & 15));
        repeat (10) @(posedge clock_in);
        #1 $display("test spacing done");
        for (int band = 0; band < 2; band++)
        begin
            test_band = band[0];
            i_host.drive(2'h0, 1'b0, {1'b0, 1'b1});
            repeat (8) @(negedge clock_in);
            check_val("no_entry", 4'hf, buf_q);
            i_host.drive(2'h0, 1'b0, {1'b1, band[0]});
            wait_bit(3, 1'b0);
            check_range("input_disable", 1, 4, n - 2);
            check_val("cke_low", 4'h0, {2'h0, cke_q});
            wait_bit(1, 1'b0);
            check_range("output_float", 2, 2, n);
            i_host.stop_clock();
            wait_bit(2, 1'b0);
            check_range("enable_disable", 2, 4, n - 2);
            v = 2'(($random(seed) & 1) + 1 + band);
            i_host.drive(v, 1'b0, {1'b1, band[0]});
            wait_bit(0, 1'b1);
            check_range("static_return", 1, 3, n - 2);
            check_val("buffers_back", 4'hf, buf_q);
            check_val("cke_follow", {2'h0, v}, {2'h0, cke_q});
            i_host.drive(2'h0, 1'b0, {1'b0, 1'b0});
            $display("test power save band %0d done", band);
        end
        i_host.drive(2'h0, 1'b0, {1'b1, 1'b0});
        v = 2'(($random(seed) & 1) + 1);
        i_host.drive(v, 1'b0, {1'b1, 1'b0});
        wait_bit(0, 1'b0);
        wait_bit(0, 1'b1);
        check_range("abort_return", 1, 3, n);
        check_val("abort_buffers", 4'hf, buf_q);
        check_val("abort_cke", {2'h0, v}, {2'h0, cke_q});
        i_host.drive(2'h0, 1'b0, {1'b0, 1'b0});
        $display("test abort done");
        finish_test();
    end
endmodule // power_sequencer_bench
`default_nettype wire
